// >>> design/ucrm_pkg.sv
package ucrm_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [3:0] ADDR_HOLDING    = 4'h0;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_INT_STATUS = 4'h2;
    localparam logic [3:0] ADDR_LINE_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_MODEM_CTRL = 4'h4;
    localparam logic [3:0] ADDR_LINE_STAT  = 4'h5;
    localparam logic [3:0] ADDR_MODEM_STAT = 4'h6;
    localparam logic [3:0] ADDR_SCRATCH    = 4'h7;
    localparam logic [3:0] ADDR_FEATURE    = 4'h8;
    localparam logic [3:0] ADDR_ENHANCED   = 4'h9;
    localparam logic [3:0] ADDR_FLOW_STAT  = 4'hC;
    localparam logic [3:0] ADDR_STOP_TWO   = 4'hD;
    localparam logic [3:0] ADDR_RESUME_ONE = 4'hE;
    localparam logic [3:0] ADDR_RESUME_TWO = 4'hF;

    // ****************************************************************
    // field positions and masks
    // ****************************************************************
    localparam int         LCR_DIV_BIT    = 7;
    localparam int         EFR_UNLOCK_BIT = 4;
    localparam int         MCR_LOOP_BIT   = 4;
    localparam int         MCR_OUT1_BIT   = 2;
    localparam int         MCR_OUT2_BIT   = 3;
    localparam logic [7:0] IER_EXT_MASK   = 8'hE0;
    localparam logic [7:0] IER_BASE_MASK  = 8'h0F;
    localparam logic [7:0] ISR_EXT_MASK   = 8'h30;
    localparam logic [7:0] FCR_EXT_MASK   = 8'h30;
    localparam logic [7:0] MCR_EXT_MASK   = 8'hEC;
    localparam logic [7:0] MCR_BASE_MASK  = 8'h13;
    localparam logic [7:0] FRAC_MASK      = 8'h0F;
    localparam logic [7:0] FEATURE_CONTROL_MASK      = 8'h30;
    localparam logic [3:0] FLOW_ZERO      = 4'h0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_LCR  = 8'h00;

    // ****************************************************************
    // host bus request
    // ****************************************************************
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ucrm_req_s;

    // ****************************************************************
    // configuration presented to the channel core
    // ****************************************************************
    typedef struct packed {
        logic [7:0] int_enable;
        logic [7:0] queue_control;
        logic [7:0] modem_control;
        logic [7:0] turnaround;
        logic [7:0] line_control;
    } ucrm_cfg_s;

endpackage

// >>> design/ucrm_regs.sv
`timescale 1ns/1ps
module ucrm_regs (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic              clk_en,
    // host bus
    input  wire ucrm_pkg::ucrm_req_s host_req,
    output logic [7:0]             host_rdata_ff,
    // channel core status
    input  wire logic [7:0]        rx_data,
    input  wire logic [7:0]        line_stat_in,
    input  wire logic [3:0]        isr_source,
    input  wire logic [1:0]        isr_ext_in,
    input  wire logic [7:0]        modem_stat_in,
    input  wire logic [3:0]        flow_event,
    // configuration and data out
    output ucrm_pkg::ucrm_cfg_s    cfg_ff,
    output logic [7:0]             tx_data_ff,
    output logic                   tx_push_ff,
    output logic [19:0]            divisor_ff,
    output logic [7:0]             feature_ff,
    output logic [7:0]             efr_ff,
    output logic [31:0]            flow_chars_ff,
    output logic [1:0]             loop_outputs_ff,
    // interrupt clear pulses
    output logic                   clr_line_int_ff,
    output logic                   clr_modem_int_ff,
    output logic                   clr_timeout_int_ff
);

    // ****************************************************************
    // decode
    // ****************************************************************
    logic       div_sel;
    logic       unlock;
    logic       wr;
    logic       rd;
    logic [3:0] a;
    logic [7:0] d;
    logic [7:0] scratch_ff;
    logic [3:0] flow_ff;
    logic [7:0] ier_mask;
    logic [7:0] mcr_mask;
    logic [7:0] rdata;

    assign div_sel  = cfg_ff.line_control[ucrm_pkg::LCR_DIV_BIT];
    assign unlock   = efr_ff[ucrm_pkg::EFR_UNLOCK_BIT];
    assign wr       = host_req.wr & clk_en;
    assign rd       = host_req.rd & clk_en;
    assign a        = host_req.addr;
    assign d        = host_req.wdata;
    assign ier_mask = unlock ? (ucrm_pkg::IER_EXT_MASK |
                                ucrm_pkg::IER_BASE_MASK)
                             : ucrm_pkg::IER_BASE_MASK;
    assign mcr_mask = unlock ? (ucrm_pkg::MCR_EXT_MASK |
                                ucrm_pkg::MCR_BASE_MASK)
                             : ucrm_pkg::MCR_BASE_MASK;

    // ****************************************************************
    // writable registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cfg_ff        <= '0;
            divisor_ff    <= '0;
            feature_ff    <= ucrm_pkg::RST_BYTE;
            efr_ff        <= ucrm_pkg::RST_BYTE;
            scratch_ff    <= ucrm_pkg::RST_BYTE;
            flow_chars_ff <= '0;
            tx_data_ff    <= ucrm_pkg::RST_BYTE;
            tx_push_ff    <= 1'b0;
        end else if (clk_en) begin
            tx_push_ff <= 1'b0;
            if (wr) begin
                unique case (a)
                    ucrm_pkg::ADDR_HOLDING: begin
                        if (div_sel) begin
                            divisor_ff[7:0] <= d;
                        end else begin
                            tx_data_ff <= d;
                            tx_push_ff <= 1'b1;
                        end
                    end
                    ucrm_pkg::ADDR_INT_ENABLE: begin
                        if (div_sel) begin
                            divisor_ff[15:8] <= d;
                        end else begin
                            cfg_ff.int_enable <= d & ier_mask;
                        end
                    end
                    ucrm_pkg::ADDR_INT_STATUS: begin
                        if (div_sel) begin
                            divisor_ff[19:16] <= d[3:0];
                        end else if (unlock) begin
                            cfg_ff.queue_control <= d;
                        end else begin
                            cfg_ff.queue_control <= d &
                                ~ucrm_pkg::FCR_EXT_MASK;
                        end
                    end
                    ucrm_pkg::ADDR_LINE_CTRL:
                        cfg_ff.line_control <= d;
                    ucrm_pkg::ADDR_MODEM_CTRL:
                        cfg_ff.modem_control <= d & mcr_mask;
                    ucrm_pkg::ADDR_MODEM_STAT: begin
                        if (unlock) begin
                            cfg_ff.turnaround <= d;
                        end
                    end
                    ucrm_pkg::ADDR_SCRATCH:   scratch_ff <= d;
                    ucrm_pkg::ADDR_FEATURE:
                        feature_ff <= d & ucrm_pkg::FEATURE_CONTROL_MASK;
                    ucrm_pkg::ADDR_ENHANCED: begin
                        efr_ff <= d;
                        if (!d[ucrm_pkg::EFR_UNLOCK_BIT]) begin
                            cfg_ff.int_enable <= cfg_ff.int_enable &
                                ~ucrm_pkg::IER_EXT_MASK;
                            cfg_ff.queue_control <= cfg_ff.queue_control &
                                ~ucrm_pkg::FCR_EXT_MASK;
                            cfg_ff.modem_control <= cfg_ff.modem_control &
                                ~ucrm_pkg::MCR_EXT_MASK;
                            cfg_ff.turnaround <= ucrm_pkg::RST_BYTE;
                        end
                    end
                    ucrm_pkg::ADDR_FLOW_STAT: flow_chars_ff[7:0] <= d;
                    ucrm_pkg::ADDR_STOP_TWO:  flow_chars_ff[15:8] <= d;
                    ucrm_pkg::ADDR_RESUME_ONE:
                        flow_chars_ff[23:16] <= d;
                    ucrm_pkg::ADDR_RESUME_TWO:
                        flow_chars_ff[31:24] <= d;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // general outputs: stored, looped back only, no pins
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            loop_outputs_ff <= 2'b00;
        end else if (clk_en) begin
            loop_outputs_ff <= cfg_ff.modem_control[ucrm_pkg::MCR_LOOP_BIT] ?
                {cfg_ff.modem_control[ucrm_pkg::MCR_OUT2_BIT],
                 cfg_ff.modem_control[ucrm_pkg::MCR_OUT1_BIT]}
                : 2'b00;
        end
    end

    // ****************************************************************
    // flow-character status, set wins over read clear
    // ****************************************************************
    logic flow_rd;
    assign flow_rd = rd & (a == ucrm_pkg::ADDR_FLOW_STAT);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flow_ff <= ucrm_pkg::FLOW_ZERO;
        end else if (clk_en) begin
            flow_ff <= (flow_rd ? ucrm_pkg::FLOW_ZERO : flow_ff)
                       | flow_event;
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rdata = ucrm_pkg::RST_BYTE;
        unique case (a)
            ucrm_pkg::ADDR_HOLDING:
                rdata = div_sel ? divisor_ff[7:0] : rx_data;
            ucrm_pkg::ADDR_INT_ENABLE:
                rdata = div_sel ? divisor_ff[15:8] : cfg_ff.int_enable;
            ucrm_pkg::ADDR_INT_STATUS: begin
                if (div_sel) begin
                    rdata = {4'h0, divisor_ff[19:16]};
                end else begin
                    rdata = {{2{cfg_ff.queue_control[0]}},
                             unlock ? isr_ext_in : 2'b00,
                             isr_source};
                end
            end
            ucrm_pkg::ADDR_LINE_CTRL:  rdata = cfg_ff.line_control;
            ucrm_pkg::ADDR_MODEM_CTRL: rdata = cfg_ff.modem_control;
            ucrm_pkg::ADDR_LINE_STAT:  rdata = line_stat_in;
            ucrm_pkg::ADDR_MODEM_STAT: rdata = modem_stat_in;
            ucrm_pkg::ADDR_SCRATCH:    rdata = scratch_ff;
            ucrm_pkg::ADDR_FEATURE:    rdata = feature_ff;
            ucrm_pkg::ADDR_ENHANCED:   rdata = efr_ff;
            ucrm_pkg::ADDR_FLOW_STAT:  rdata = {4'h0, flow_ff};
            default:                   rdata = ucrm_pkg::RST_BYTE;
        endcase
    end

    // ****************************************************************
    // read data and interrupt clear pulses
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            host_rdata_ff      <= ucrm_pkg::RST_BYTE;
            clr_line_int_ff    <= 1'b0;
            clr_modem_int_ff   <= 1'b0;
            clr_timeout_int_ff <= 1'b0;
        end else if (clk_en) begin
            if (rd) begin
                host_rdata_ff <= rdata;
            end
            clr_line_int_ff    <= rd &
                                  (a == ucrm_pkg::ADDR_LINE_STAT);
            clr_modem_int_ff   <= rd &
                                  (a == ucrm_pkg::ADDR_MODEM_STAT);
            clr_timeout_int_ff <= rd & !div_sel &
                                  (a == ucrm_pkg::ADDR_HOLDING);
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_ier_locked: assert property (
        !unlock |-> (cfg_ff.int_enable & ucrm_pkg::IER_EXT_MASK) == 8'h00)
        else $error("extended interrupt enable set while locked");
    chk_mcr_locked: assert property (
        (clk_en && wr && a == ucrm_pkg::ADDR_MODEM_CTRL && !unlock)
        |=> (cfg_ff.modem_control & ucrm_pkg::MCR_EXT_MASK) == 8'h00)
        else $error("extended modem control written while locked");
    chk_flow_clear: assert property (
        (flow_rd && flow_event == 4'h0) |=> flow_ff == 4'h0)
        else $error("flow status not cleared by read");
    chk_flow_set: assert property (
        (clk_en && flow_event != 4'h0) |=> (flow_ff & $past(flow_event))
        == $past(flow_event))
        else $error("flow event lost");
    chk_loop_route: assert property (
        (clk_en && !cfg_ff.modem_control[ucrm_pkg::MCR_LOOP_BIT]) |=>
        loop_outputs_ff == 2'b00)
        else $error("general outputs leak outside loopback");
    chk_div_write: assert property (
        (wr && div_sel && a == ucrm_pkg::ADDR_HOLDING) |=>
        divisor_ff[7:0] == $past(d) && !tx_push_ff)
        else $error("divisor bank write misrouted");
    chk_tx_push: assert property (
        (wr && !div_sel && a == ucrm_pkg::ADDR_HOLDING) |=> tx_push_ff)
        else $error("transmit write not pushed");
    chk_line_clr: assert property (
        (rd && a == ucrm_pkg::ADDR_LINE_STAT) |=> clr_line_int_ff)
        else $error("line status read did not clear");
    chk_modem_clr: assert property (
        (clr_modem_int_ff && $past(clk_en)) |->
        $past(rd && a == ucrm_pkg::ADDR_MODEM_STAT))
        else $error("spurious modem clear");
    chk_timeout_clr: assert property (
        (rd && !div_sel && a == ucrm_pkg::ADDR_HOLDING) |=>
        clr_timeout_int_ff)
        else $error("holding read did not clear timeout");
    chk_mcr_idle: assert property (
        !unlock |-> (cfg_ff.modem_control & ucrm_pkg::MCR_EXT_MASK) == 8'h00)
        else $error("extended modem control active while locked");
    chk_fcr_idle: assert property (
        !unlock |-> (cfg_ff.queue_control & ucrm_pkg::FCR_EXT_MASK) == 8'h00)
        else $error("extended queue control active while locked");
    chk_turn_idle: assert property (
        !unlock |-> cfg_ff.turnaround == ucrm_pkg::RST_BYTE)
        else $error("turnaround byte active while locked");
    chk_isr_gated: assert property (
        (rd && !div_sel && a == ucrm_pkg::ADDR_INT_STATUS && !unlock) |=>
        (host_rdata_ff & ucrm_pkg::ISR_EXT_MASK) == 8'h00)
        else $error("extended status bits read while locked");
    chk_ier_base: assert property (
        (wr && !div_sel && a == ucrm_pkg::ADDR_INT_ENABLE && !unlock) |=>
        cfg_ff.int_enable == ($past(d) & ucrm_pkg::IER_BASE_MASK))
        else $error("interrupt enable write not masked");
    chk_ier_full: assert property (
        (wr && !div_sel && a == ucrm_pkg::ADDR_INT_ENABLE && unlock) |=>
        cfg_ff.int_enable == ($past(d) & (ucrm_pkg::IER_EXT_MASK |
                                         ucrm_pkg::IER_BASE_MASK)))
        else $error("unlocked interrupt enable write lost");
    chk_rsvd_zero: assert property (
        (rd && a[3:1] == 3'b101) |=> host_rdata_ff == ucrm_pkg::RST_BYTE)
        else $error("reserved location read not zero");
    chk_flow_read: assert property (
        flow_rd |=> host_rdata_ff == {4'h0, $past(flow_ff)})
        else $error("flow status read lost indicators");
    chk_loop_on: assert property (
        (clk_en && cfg_ff.modem_control[ucrm_pkg::MCR_LOOP_BIT]) |=>
        loop_outputs_ff ==
        $past({cfg_ff.modem_control[ucrm_pkg::MCR_OUT2_BIT],
               cfg_ff.modem_control[ucrm_pkg::MCR_OUT1_BIT]}))
        else $error("general outputs not looped back");
    chk_frac_write: assert property (
        (wr && div_sel && a == ucrm_pkg::ADDR_INT_STATUS) |=>
        divisor_ff[19:16] == $past(d[3:0]))
        else $error("divisor fraction write misrouted");
    chk_tx_data: assert property (
        (wr && !div_sel && a == ucrm_pkg::ADDR_HOLDING) |=>
        tx_data_ff == $past(d))
        else $error("transmit byte not captured");
    chk_modem_pulse: assert property (
        (rd && a == ucrm_pkg::ADDR_MODEM_STAT) |=> clr_modem_int_ff)
        else $error("modem status read did not clear");
    chk_line_only: assert property (
        (clr_line_int_ff && $past(clk_en)) |->
        $past(rd && a == ucrm_pkg::ADDR_LINE_STAT))
        else $error("spurious line clear");
    chk_timeout_only: assert property (
        (clr_timeout_int_ff && $past(clk_en)) |->
        $past(rd && !div_sel && a == ucrm_pkg::ADDR_HOLDING))
        else $error("spurious timeout clear");
    chk_rd_hold: assert property (
        !rd |=> $stable(host_rdata_ff))
        else $error("read data changed without a read");
    chk_freeze: assert property (
        !clk_en |=> $stable(cfg_ff) && $stable(divisor_ff))
        else $error("configuration changed while frozen");

    // ****************************************************************
    // scenario coverage
    // ****************************************************************
    cov_div_write: cover property (wr && div_sel);
    cov_unlock:    cover property (unlock && wr &&
                                   a == ucrm_pkg::ADDR_INT_ENABLE);
    cov_flow_rd:   cover property (flow_rd && flow_ff != 4'h0);
    cov_loopback:  cover property (clk_en && loop_outputs_ff != 2'b00);
    cov_relock:    cover property (wr && unlock &&
                                   a == ucrm_pkg::ADDR_ENHANCED &&
                                   !d[ucrm_pkg::EFR_UNLOCK_BIT]);

endmodule

// >>> verif/ucrm_host_model.sv
`timescale 1ns/1ps
module ucrm_host_model (
    // clock
    input  wire logic            ref_clk,
    // host bus
    output ucrm_pkg::ucrm_req_s  host_req
);
    logic [7:0] junk;

    // ************************************************************
    // bus cycles, launched on the falling edge
    // ************************************************************
    task automatic access(input logic r, input logic w,
                          input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        host_req <= '{rd: r, wr: w, addr: a, wdata: d};
    endtask

    // released bus: address and data keep changing
    task automatic idle();
        @(negedge ref_clk);
        junk = ~junk + 8'h01;
        host_req <= '{rd: 1'b0, wr: 1'b0, addr: junk[3:0], wdata: junk};
    endtask

    initial begin
        junk = 8'h5a;
        host_req = '0;
    end
endmodule

// >>> verif/tb_uart_channel_register_map.sv
`timescale 1ns/1ps
module tb_uart_channel_register_map;
    logic                 ref_clk, nrst, clk_en, tx_push_ff, lcr7, rd_seen;
    logic                 clr_line_int_ff, clr_modem_int_ff;
    logic                 clr_timeout_int_ff;
    ucrm_pkg::ucrm_req_s  host_req;
    ucrm_pkg::ucrm_cfg_s  cfg_ff;
    logic [7:0]           host_rdata_ff, rx_data, line_stat_in;
    logic [7:0]           modem_stat_in, tx_data_ff, feature_ff, efr_ff, d;
    logic [3:0]           isr_source, flow_event;
    logic [1:0]           isr_ext_in, loop_outputs_ff;
    logic [19:0]          divisor_ff;
    logic [31:0]          flow_chars_ff, fc, lfsr;
    logic [10:0]          exp_q[$];
    int                   n_mismatch, n_tests;

    ucrm_host_model host (.ref_clk(ref_clk), .host_req(host_req));

    ucrm_regs uut (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
        .host_req(host_req), .host_rdata_ff(host_rdata_ff),
        .rx_data(rx_data), .line_stat_in(line_stat_in),
        .isr_source(isr_source), .isr_ext_in(isr_ext_in),
        .modem_stat_in(modem_stat_in), .flow_event(flow_event),
        .cfg_ff(cfg_ff), .tx_data_ff(tx_data_ff), .tx_push_ff(tx_push_ff),
        .divisor_ff(divisor_ff), .feature_ff(feature_ff), .efr_ff(efr_ff),
        .flow_chars_ff(flow_chars_ff), .loop_outputs_ff(loop_outputs_ff),
        .clr_line_int_ff(clr_line_int_ff),
        .clr_modem_int_ff(clr_modem_int_ff),
        .clr_timeout_int_ff(clr_timeout_int_ff)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction

    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [10:0] got, input logic [10:0] exp);
        chk_out({21'h0_0000, got}, {21'h0_0000, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        host.access(1'b0, 1'b1, a, v);
        if (a == ucrm_pkg::ADDR_LINE_CTRL) begin
            lcr7 = v[7];
        end
    endtask

    // note data and the expected clear pulses {line, modem, timeout}
    task automatic rd(input logic [3:0] a, input logic [7:0] v);
        exp_q.push_back({a == 4'h5, a == 4'h6, a == 4'h0 && !lcr7, v});
        host.access(1'b1, 1'b0, a, 8'h00);
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // clock, watchdog and read monitor
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (2000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    always @(posedge ref_clk) rd_seen <= nrst && clk_en && host_req.rd;

    always @(negedge ref_clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            chk_rd({clr_line_int_ff, clr_modem_int_ff, clr_timeout_int_ff,
                    host_rdata_ff}, exp_q.pop_front());
        end else if (rd_seen === 1'b1) begin
            chk_rd(11'h000, 11'h7ff);
        end else if (nrst === 1'b1) begin
            chk_out({29'h0, clr_line_int_ff, clr_modem_int_ff,
                     clr_timeout_int_ff}, 32'h0);
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        lfsr = 32'he945;
        lcr7 = 1'b0;
        nrst = 1'b0;
        clk_en = 1'b1;
        rx_data = rnd();
        line_stat_in = rnd();
        modem_stat_in = rnd();
        isr_source = 4'h6;
        isr_ext_in = 2'b11;
        flow_event = 4'h0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        rd(4'h1, 8'h00);
        rd(4'h3, 8'h00);
        rd(4'h9, 8'h00);
        d = rnd();
        wr(4'h7, d);
        rd(4'h7, d);
        rd(4'hA, 8'h00);
        rd(4'hB, 8'h00);
        host.idle();
        clk_en = 1'b0;
        host.access(1'b0, 1'b1, 4'h7, ~d);
        host.idle();
        clk_en = 1'b1;
        rd(4'h7, d);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'h0F);
        wr(4'h4, 8'hFF);
        rd(4'h4, 8'h13);
        wr(4'h6, 8'hA5);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'hC6);
        host.idle();
        chk_out(cfg_ff.turnaround, 32'h0);
        chk_out(cfg_ff.queue_control, 8'hCF);
        chk_out(loop_outputs_ff, 32'h0);
        wr(4'h9, 8'h10);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'hEF);
        wr(4'h4, 8'h1C);
        wr(4'h6, 8'hA5);
        wr(4'h2, 8'hFF);
        rd(4'h2, 8'hF6);
        host.idle();
        chk_out(loop_outputs_ff, 32'h3);
        chk_out(cfg_ff.turnaround, 8'hA5);
        chk_out(cfg_ff.queue_control, 8'hFF);
        chk_out(efr_ff, 8'h10);
        wr(4'h4, 8'h0C);
        host.idle();
        host.idle();
        chk_out(loop_outputs_ff, 32'h0);
        // divisor bank opened before the divisor is written
        wr(4'h3, 8'h83);
        wr(4'h0, 8'h34);
        wr(4'h1, 8'h12);
        wr(4'h2, 8'hFB);
        rd(4'h0, 8'h34);
        rd(4'h1, 8'h12);
        rd(4'h2, 8'h0B);
        host.idle();
        chk_out(divisor_ff, 20'hB_1234);
        chk_out(cfg_ff.int_enable, 8'hEF);
        wr(4'h3, 8'h03);
        d = rnd();
        wr(4'h0, d);
        host.idle();
        chk_out({tx_push_ff, tx_data_ff}, {1'b1, d});
        host.idle();
        chk_out(tx_push_ff, 32'h0);
        rd(4'h0, rx_data);
        rd(4'h5, line_stat_in);
        rd(4'h6, modem_stat_in);
        for (int k = 0; k < 2; k++) begin
            host.idle();
            flow_event = k ? 4'h5 : 4'hA;
            host.idle();
            flow_event = 4'h0;
            rd(4'hC, k ? 8'h05 : 8'h0A);
            rd(4'hC, 8'h00);
        end
        for (int a = 12; a < 16; a++) begin
            d = rnd();
            fc[(a - 12) * 8 +: 8] = d;
            wr(a[3:0], d);
        end
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h30);
        host.idle();
        chk_out(flow_chars_ff, fc);
        chk_out(feature_ff, 8'h30);
        wr(4'h9, 8'h00);
        rd(4'h1, 8'h0F);
        rd(4'h4, 8'h00);
        host.idle();
        chk_out(cfg_ff.turnaround, 32'h0);
        chk_out(cfg_ff.queue_control, 8'hCF);
        host.idle();
        chk_out(exp_q.size(), 32'h0);
        wrap_up();
    end
endmodule
